// ---- common/tmw_pkg.sv ----
// shared constants for the 16-bit timer waveform output block
package tmw_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int PRESC_W = 10;
    localparam int CHANNELS = 2;

    // register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL    = 5'h00;
    localparam logic [ADDR_W-1:0] REG_COUNT   = 5'h04;
    localparam logic [ADDR_W-1:0] REG_CMP_A   = 5'h08;
    localparam logic [ADDR_W-1:0] REG_CMP_B   = 5'h0C;
    localparam logic [ADDR_W-1:0] REG_CAPTURE = 5'h10;
    localparam logic [ADDR_W-1:0] REG_FLAGS   = 5'h14;
    localparam logic [ADDR_W-1:0] REG_FORCE   = 5'h18;
    localparam logic [ADDR_W-1:0] REG_STATUS  = 5'h1C;

    // control field positions
    localparam int CTRL_WAVE_LSB   = 0;
    localparam int CTRL_MODE_A_LSB = 4;
    localparam int CTRL_MODE_B_LSB = 6;
    localparam int CTRL_CLKSEL_LSB = 8;
    localparam int CTRL_DIR_A      = 11;
    localparam int CTRL_DIR_B      = 12;
    localparam int CTRL_PORT_A     = 13;
    localparam int CTRL_PORT_B     = 14;

    // flag bit positions
    localparam int FLAG_OVF   = 0;
    localparam int FLAG_CMP_A = 1;
    localparam int FLAG_CMP_B = 2;
    localparam int FLAG_CAPT  = 3;

    // reset values
    localparam logic [DATA_W-1:0] CTRL_RESET  = 16'h0000;
    localparam logic [DATA_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] CMP_RESET   = 16'h0000;
    localparam logic [DATA_W-1:0] CAPT_RESET  = 16'h0000;
    localparam logic [3:0]        FLAGS_RESET = 4'h0;

    // waveform mode field values
    localparam logic [3:0] WAVE_NORMAL    = 4'h0;
    localparam logic [3:0] WAVE_CTC_CMP   = 4'h4;
    localparam logic [3:0] WAVE_FAST_8    = 4'h5;
    localparam logic [3:0] WAVE_FAST_9    = 4'h6;
    localparam logic [3:0] WAVE_FAST_10   = 4'h7;
    localparam logic [3:0] WAVE_CTC_CAPT  = 4'hC;
    localparam logic [3:0] WAVE_FAST_CAPT = 4'hE;
    localparam logic [3:0] WAVE_FAST_CMP  = 4'hF;

    // counter extremes and fixed tops
    localparam logic [DATA_W-1:0] TOP_MAX      = 16'hFFFF;
    localparam logic [DATA_W-1:0] TOP_8        = 16'h00FF;
    localparam logic [DATA_W-1:0] TOP_9        = 16'h01FF;
    localparam logic [DATA_W-1:0] TOP_10       = 16'h03FF;
    localparam logic [DATA_W-1:0] COUNT_BOTTOM = 16'h0000;

    // compare output mode values
    localparam logic [1:0] OUT_NONE   = 2'h0;
    localparam logic [1:0] OUT_TOGGLE = 2'h1;
    localparam logic [1:0] OUT_CLEAR  = 2'h2;
    localparam logic [1:0] OUT_SET    = 2'h3;

    // clock select values and prescaler masks
    localparam logic [2:0] CLK_STOP    = 3'h0;
    localparam logic [2:0] CLK_DIV1    = 3'h1;
    localparam logic [2:0] CLK_DIV8    = 3'h2;
    localparam logic [2:0] CLK_DIV64   = 3'h3;
    localparam logic [2:0] CLK_DIV256  = 3'h4;
    localparam logic [2:0] CLK_DIV1024 = 3'h5;
    localparam logic [PRESC_W-1:0] MASK_DIV1    = 10'h000;
    localparam logic [PRESC_W-1:0] MASK_DIV8    = 10'h007;
    localparam logic [PRESC_W-1:0] MASK_DIV64   = 10'h03F;
    localparam logic [PRESC_W-1:0] MASK_DIV256  = 10'h0FF;
    localparam logic [PRESC_W-1:0] MASK_DIV1024 = 10'h3FF;
    localparam logic [PRESC_W-1:0] PRESC_RESET  = 10'h000;

endpackage

// ---- verilog/tmw_prescaler.sv ----
// timer clock enable divider for the waveform timer
`timescale 1ns/100ps
module tmw_prescaler
    import tmw_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [2:0] clk_select,
    output logic            timer_tick
);

    logic [PRESC_W-1:0] div_count;
    logic [PRESC_W-1:0] sel_mask;
    logic               sel_valid;

    // free running, so a new factor takes effect without a restart
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_count <= PRESC_RESET;
        end else begin
            div_count <= div_count + 10'h001;
        end
    end

    assign sel_mask = (clk_select == CLK_DIV8)    ? MASK_DIV8 :
                      (clk_select == CLK_DIV64)   ? MASK_DIV64 :
                      (clk_select == CLK_DIV256)  ? MASK_DIV256 :
                      (clk_select == CLK_DIV1024) ? MASK_DIV1024 : MASK_DIV1; // [RULE15]
    assign sel_valid = (clk_select != CLK_STOP) && (clk_select <= CLK_DIV1024);
    assign timer_tick = sel_valid && ((div_count & sel_mask) == sel_mask); // [RULE15]

endmodule

// ---- verilog/tmw_timer.sv ----
// 16-bit timer with compare output waveform generation
`timescale 1ns/100ps
// Summary of operation
// RULE1: reset clears each output compare state to zero.
// RULE2: nonzero output mode routes state to pin; direction bit still enables.
// RULE3: output state can be preset while the pin is not driven.
// RULE4: output mode never affects capture behaviour.
// RULE5: output mode zero leaves the state untouched on match.
// RULE6: new output mode acts at next match; force applies it at once.
// RULE7: counting depends on waveform mode only, not output mode.
// RULE8: mode zero counts up freely, wrapping 0xFFFF to 0x0000.
// RULE9: normal mode overflow flag sets as counter becomes zero; software clears.
// RULE10: counter writes accepted at any time in normal mode.
// RULE11: modes 4 and 12 clear counter at compare A or capture value.
// RULE12: clear-on-match top unbuffered; low top means wrap via maximum first.
// RULE13: reaching top sets compare A flag or capture flag accordingly.
// RULE14: channel A toggle mode in clear-on-match toggles on every match.
// RULE15: timer tick divides clock by 1, 8, 64, 256 or 1024.
// RULE16: clear-on-match overflow flag sets on maximum to zero pass.
// RULE17: modes 5, 6, 7, 14, 15 are single-slope fast PWM.
// RULE18: fast PWM non-inverting sets on match, clears at top; inverting opposite.
// RULE19: fast PWM tops 0xFF, 0x1FF, 0x3FF, capture, compare A; clear next tick.
// RULE20: software keeps variable top at least 0x0003.
// RULE21: fast PWM compare match sets that channel's flag.
// RULE22: PWM compare writes are buffered and loaded at top.
// RULE23: force updates state only, no flag, no counter effect.
// RULE24: fast PWM overflow flag sets each time top is reached.
// RULE25: fast PWM mode two non-inverted, mode three inverted.
// RULE26: counter compared with each compare value per tick, one-cycle match.
module tmw_timer
    import tmw_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic [3:0]        flag_ack,
    output logic      [3:0]        event_flags,
    output logic                   pin_a_out,
    output logic                   pin_a_oe,
    output logic                   pin_b_out,
    output logic                   pin_b_oe
);

    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] counter;
    logic [DATA_W-1:0] capture_value;
    logic [DATA_W-1:0] cmp_buf [CHANNELS];
    logic [DATA_W-1:0] cmp_active [CHANNELS];
    logic [3:0]        flags;
    logic [CHANNELS-1:0] oc_state;
    logic              match_block;
    logic [DATA_W-1:0] next_counter;
    logic [DATA_W-1:0] next_rdata;
    logic [3:0]        next_flags;

    // decode wires
    logic              wr_ctrl;
    logic              wr_count;
    logic              wr_capture;
    logic              wr_flags;
    logic              wr_force;
    logic [CHANNELS-1:0] wr_cmp;
    logic [3:0]        wave;
    logic [2:0]        clk_select;
    logic              timer_tick;
    logic              mode_fast;
    logic              mode_ctc;
    logic              top_from_capture;
    logic              top_from_cmp;
    logic [DATA_W-1:0] top_value;
    logic              top_hit;
    logic              ovf_event;
    logic [CHANNELS-1:0] match;
    logic [CHANNELS-1:0] force_hit;
    logic [1:0]        out_mode [CHANNELS];
    logic [CHANNELS-1:0] pin_dir;
    logic [CHANNELS-1:0] pin_port;
    logic [3:0]        flag_set;
    logic [3:0]        flag_clr;

    function automatic logic is_fast(input logic [3:0] w);
        is_fast = (w == WAVE_FAST_8) || (w == WAVE_FAST_9) || (w == WAVE_FAST_10) ||
                  (w == WAVE_FAST_CAPT) || (w == WAVE_FAST_CMP);
    endfunction

    // non-PWM action on a match or a force strobe
    function automatic logic match_action(input logic [1:0] m, input logic cur);
        case (m)
            OUT_TOGGLE: match_action = ~cur; // [RULE14]
            OUT_CLEAR:  match_action = 1'b0;
            OUT_SET:    match_action = 1'b1;
            default:    match_action = cur; // [RULE5]
        endcase
    endfunction

    assign wr_ctrl    = reg_write && (reg_addr == REG_CTRL);
    assign wr_count   = reg_write && (reg_addr == REG_COUNT);
    assign wr_cmp[0]  = reg_write && (reg_addr == REG_CMP_A);
    assign wr_cmp[1]  = reg_write && (reg_addr == REG_CMP_B);
    assign wr_capture = reg_write && (reg_addr == REG_CAPTURE);
    assign wr_flags   = reg_write && (reg_addr == REG_FLAGS);
    assign wr_force   = reg_write && (reg_addr == REG_FORCE);

    assign wave        = ctrl[CTRL_WAVE_LSB +: 4];
    assign clk_select  = ctrl[CTRL_CLKSEL_LSB +: 3];
    assign out_mode[0] = ctrl[CTRL_MODE_A_LSB +: 2];
    assign out_mode[1] = ctrl[CTRL_MODE_B_LSB +: 2];
    assign pin_dir     = {ctrl[CTRL_DIR_B], ctrl[CTRL_DIR_A]};
    assign pin_port    = {ctrl[CTRL_PORT_B], ctrl[CTRL_PORT_A]};

    tmw_prescaler u_prescaler (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .clk_select (clk_select),
        .timer_tick (timer_tick)
    );

    // sequence is chosen by waveform mode alone, output mode never enters here
    assign mode_fast = is_fast(wave); // [RULE7] [RULE17]
    assign mode_ctc  = (wave == WAVE_CTC_CMP) || (wave == WAVE_CTC_CAPT); // [RULE11]
    assign top_from_cmp     = (wave == WAVE_CTC_CMP) || (wave == WAVE_FAST_CMP);
    assign top_from_capture = (wave == WAVE_CTC_CAPT) || (wave == WAVE_FAST_CAPT);
    assign top_value = top_from_cmp           ? cmp_active[0] :
                       top_from_capture       ? capture_value :
                       (wave == WAVE_FAST_8)  ? TOP_8 :
                       (wave == WAVE_FAST_9)  ? TOP_9 :
                       (wave == WAVE_FAST_10) ? TOP_10 : TOP_MAX; // [RULE19]

    // exact equality only: a top below the count is missed until the wrap
    assign top_hit = timer_tick && !match_block && (mode_ctc || mode_fast) &&
                     (counter == top_value); // [RULE11] [RULE12] [RULE19]

    // counter write blocks matches for one tick, top included
    assign next_counter = wr_count   ? reg_wdata : // [RULE10]
                          top_hit    ? COUNT_BOTTOM : // [RULE11] [RULE19]
                          timer_tick ? counter + 16'h0001 : counter; // [RULE8]

    assign ovf_event = mode_fast ? top_hit : // [RULE24]
                       (timer_tick && (counter == TOP_MAX)); // [RULE9] [RULE16]

    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
            logic next_oc;
            logic pwm_toggle_ok;

            assign match[gi] = timer_tick && !match_block &&
                               (counter == cmp_active[gi]); // [RULE26]
            assign force_hit[gi] = wr_force && reg_wdata[gi] && !mode_fast; // [RULE6] [RULE23]
            assign pwm_toggle_ok = (gi == 0) && (wave == WAVE_FAST_CMP);

            // match wins over top so compare equal to top gives a steady level
            assign next_oc =
                !mode_fast ? ((match[gi] || force_hit[gi]) ?
                              match_action(out_mode[gi], oc_state[gi]) : oc_state[gi]) :
                (out_mode[gi] == OUT_CLEAR) ? (match[gi] ? 1'b1 :
                                               top_hit ? 1'b0 : oc_state[gi]) : // [RULE18] [RULE25]
                (out_mode[gi] == OUT_SET)   ? (match[gi] ? 1'b0 :
                                               top_hit ? 1'b1 : oc_state[gi]) : // [RULE18] [RULE25]
                (out_mode[gi] == OUT_TOGGLE && pwm_toggle_ok && match[gi]) ?
                    ~oc_state[gi] : oc_state[gi]; // [RULE5]

            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    oc_state[gi] <= 1'b0; // [RULE1]
                end else begin
                    oc_state[gi] <= next_oc; // [RULE3] [RULE6]
                end
            end

            // pwm writes land in the buffer and load at top; otherwise direct
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cmp_buf[gi]    <= CMP_RESET;
                    cmp_active[gi] <= CMP_RESET;
                end else begin
                    if (wr_cmp[gi]) begin
                        cmp_buf[gi] <= reg_wdata;
                    end
                    if (wr_cmp[gi] && !mode_fast) begin
                        cmp_active[gi] <= reg_wdata; // [RULE12]
                    end else if (mode_fast && top_hit) begin
                        cmp_active[gi] <= cmp_buf[gi]; // [RULE22]
                    end
                end
            end
        end
    endgenerate

    // pin mux: override only when output mode nonzero, direction bit gates
    assign pin_a_out = (out_mode[0] != OUT_NONE) ? oc_state[0] : pin_port[0]; // [RULE2]
    assign pin_b_out = (out_mode[1] != OUT_NONE) ? oc_state[1] : pin_port[1]; // [RULE2]
    assign pin_a_oe  = pin_dir[0]; // [RULE2]
    assign pin_b_oe  = pin_dir[1]; // [RULE2]

    // force strobes never reach the flags
    assign flag_set[FLAG_OVF]   = ovf_event; // [RULE9] [RULE16] [RULE24]
    assign flag_set[FLAG_CMP_A] = match[0]; // [RULE13] [RULE21]
    assign flag_set[FLAG_CMP_B] = match[1]; // [RULE21]
    // capture flag follows top only, independent of output mode
    assign flag_set[FLAG_CAPT]  = top_hit && top_from_capture; // [RULE13] [RULE4]
    assign flag_clr = (wr_flags ? reg_wdata[3:0] : 4'h0) | flag_ack;
    assign next_flags = (flags & ~flag_clr) | flag_set; // [RULE9]
    assign event_flags = flags;

    assign next_rdata =
        !reg_read                    ? 16'h0000 :
        (reg_addr == REG_CTRL)       ? ctrl :
        (reg_addr == REG_COUNT)      ? counter :
        (reg_addr == REG_CMP_A)      ? cmp_buf[0] :
        (reg_addr == REG_CMP_B)      ? cmp_buf[1] :
        (reg_addr == REG_CAPTURE)    ? capture_value :
        (reg_addr == REG_FLAGS)      ? {12'h000, flags} :
        (reg_addr == REG_STATUS)     ? {14'h0000, oc_state} : 16'h0000;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl          <= CTRL_RESET;
            counter       <= COUNT_RESET;
            capture_value <= CAPT_RESET;
            flags         <= FLAGS_RESET;
            match_block   <= 1'b0;
            reg_rdata     <= 16'h0000;
        end else begin
            if (wr_ctrl) begin
                ctrl <= reg_wdata;
            end
            if (wr_capture) begin
                capture_value <= reg_wdata; // [RULE12]
            end
            counter   <= next_counter;
            flags     <= next_flags;
            reg_rdata <= next_rdata;
            if (wr_count) begin
                match_block <= 1'b1;
            end else if (timer_tick) begin
                match_block <= 1'b0;
            end
        end
    end

endmodule

// ---- verification/tmw_load.sv ----
// external load on an output compare pin, pulled low when undriven
`timescale 1ns/100ps
module tmw_load (
    input  wire logic drive,
    input  wire logic enable,
    output logic      level
);
    // pull-down: a released pin never shows its last driven value
    assign level = enable ? drive : 1'b0;
endmodule

// ---- verification/tmw_timer_props.sv ----
// port assertions for the waveform timer
`timescale 1ns/100ps
module tmw_timer_props
    import tmw_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_write,
    input wire logic              reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic [3:0]        flag_ack,
    input wire logic [3:0]        event_flags,
    input wire logic              pin_a_out,
    input wire logic              pin_a_oe,
    input wire logic              pin_b_out,
    input wire logic              pin_b_oe
);
    logic [DATA_W-1:0] ctrl;
    logic              stop_q;
    wire logic [2:0] csel = ctrl[10:8];
    wire logic [1:0] mode_a = ctrl[5:4];
    wire logic [1:0] mode_b = ctrl[7:6];
    wire logic stop_now = (csel == CLK_STOP) || (csel > CLK_DIV1024);
    // stop must also hold the cycle before; the tick itself is combinational from ctrl
    wire logic stopped = stop_now && stop_q;
    wire logic fast = ctrl[3:0] inside {WAVE_FAST_8, WAVE_FAST_9, WAVE_FAST_10,
                                        WAVE_FAST_CAPT, WAVE_FAST_CMP};
    wire logic force_a = reg_write && reg_addr == REG_FORCE && reg_wdata[0] && stopped;
    wire logic flag_wr = reg_write && reg_addr == REG_FLAGS;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl   <= CTRL_RESET;
            stop_q <= 1'b1;
        end else begin
            if (reg_write && reg_addr == REG_CTRL) begin
                ctrl <= reg_wdata;
            end
            stop_q <= stop_now;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_reset_state;
        $rose(rst_n) |-> event_flags == 4'h0 && !pin_a_oe && !pin_b_oe;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("state after reset");
    property p_oe;
        pin_a_oe == ctrl[CTRL_DIR_A] && pin_b_oe == ctrl[CTRL_DIR_B];
    endproperty
    a_oe: assert property (p_oe) else $error("pin enable not from direction");
    property p_src_a;
        mode_a == OUT_NONE |-> pin_a_out == ctrl[CTRL_PORT_A];
    endproperty
    a_src_a: assert property (p_src_a) else $error("pin a source");
    property p_src_b;
        mode_b == OUT_NONE |-> pin_b_out == ctrl[CTRL_PORT_B];
    endproperty
    a_src_b: assert property (p_src_b) else $error("pin b source");
    property p_force_a;
        force_a && !fast && mode_a != OUT_NONE |=> pin_a_out ==
            (mode_a == OUT_SET || (mode_a == OUT_TOGGLE && !$past(pin_a_out)));
    endproperty
    a_force_a: assert property (p_force_a) else $error("force action wrong");
    property p_force_fast;
        force_a && fast |=> $stable(pin_a_out);
    endproperty
    a_force_fast: assert property (p_force_fast) else $error("force acted in pwm");
    property p_idle_flags;
        stopped && flag_ack == 4'h0 && !flag_wr |=> $stable(event_flags);
    endproperty
    a_idle_flags: assert property (p_idle_flags) else $error("flag moved");
    property p_ack;
        stopped && flag_ack != 4'h0 |=> (event_flags & $past(flag_ack)) == 4'h0;
    endproperty
    a_ack: assert property (p_ack) else $error("ack did not clear");
    property p_sw_clear;
        stopped && flag_wr |=> (event_flags & $past(reg_wdata[3:0])) == 4'h0;
    endproperty
    a_sw_clear: assert property (p_sw_clear) else $error("write did not clear");
    c_force: cover property (force_a && !fast);
    c_ack: cover property (stopped && flag_ack != 4'h0);
    c_pwm: cover property (fast && $rose(pin_b_out));
endmodule
bind tmw_timer tmw_timer_props i_props (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .flag_ack(flag_ack),
    .event_flags(event_flags), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
    .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe));

// ---- verification/tb.sv ----
// self-checking bench for the waveform timer
`timescale 1ns/100ps
module tb
    import tmw_pkg::*;
;
    logic              ref_clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic              reg_write = 1'b0;
    logic              reg_read = 1'b0;
    logic [3:0]        flag_ack = 4'h0;
    logic [DATA_W-1:0] reg_rdata, d;
    logic [3:0]        event_flags;
    logic              pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, level_a, level_b;
    int                fail_count = 0;
    int                checks_done = 0;
    int                hi, tg;
    always #4 ref_clk = ~ref_clk;
    tmw_timer i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .flag_ack(flag_ack), .event_flags(event_flags),
        .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out),
        .pin_b_oe(pin_b_oe));
    tmw_load i_load_a (.drive(pin_a_out), .enable(pin_a_oe), .level(level_a));
    tmw_load i_load_b (.drive(pin_b_out), .enable(pin_b_oe), .level(level_b));
    task chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge ref_clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_write <= 1'b0;
        // step off the launching edge so pins are settled when sampled
        #1;
    endtask
    task rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        @(posedge ref_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        logic [DATA_W-1:0] v;
        rd(a, v);
        chk(v, e);
    endtask
    // counts high cycles and level changes seen by the load
    task watch(input bit b, input int span, output int h, output int t);
        logic v, p;
        h = 0;
        t = 0;
        @(negedge ref_clk);
        p = b ? level_b : level_a;
        repeat (span) begin
            @(negedge ref_clk);
            v = b ? level_b : level_a;
            h += v;
            t += (v != p);
            p = v;
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdc(REG_CTRL, 16'h0000);
        rdc(REG_STATUS, 16'h0000);
        rdc(5'h02, 16'h0000);
        wr(REG_CTRL, 16'h0030);
        wr(REG_FORCE, 16'h0001);
        rdc(REG_STATUS, 16'h0001);
        chk(16'(level_a), 16'h0000);
        wr(REG_CTRL, 16'h0830);
        chk(16'(level_a), 16'h0001);
        wr(REG_CTRL, 16'h0800);
        chk(16'(level_a), 16'h0000);
        wr(REG_FORCE, 16'h0001);
        rdc(REG_STATUS, 16'h0001);
        wr(REG_CTRL, 16'h0810);
        wr(REG_FORCE, 16'h0001);
        rdc(REG_STATUS, 16'h0000);
        rdc(REG_FLAGS, 16'h0000);
        wr(REG_COUNT, 16'h1234);
        rdc(REG_COUNT, 16'h1234);
        wr(REG_COUNT, 16'hFFFC);
        wr(REG_CTRL, 16'h0100);
        repeat (8) @(posedge ref_clk);
        wr(REG_CTRL, 16'h0000);
        rd(REG_COUNT, d);
        chk(16'(d < 16'h0010), 16'h0001);
        rdc(REG_FLAGS, 16'h0007);
        wr(REG_FLAGS, 16'h000F);
        rdc(REG_FLAGS, 16'h0000);
        wr(REG_CMP_A, 16'h0002);
        wr(REG_CAPTURE, 16'h0004);
        for (int i = 0; i < 2; i++) begin
            wr(REG_COUNT, 16'h0000);
            wr(REG_CTRL, i ? 16'h091C : 16'h0914);
            repeat (6) @(posedge ref_clk);
            watch(1'b0, i ? 30 : 18, hi, tg);
            chk(16'(tg), 16'h0006);
            wr(REG_CTRL, 16'h0800);
            repeat (2) @(posedge ref_clk);
            rdc(REG_FLAGS, i ? 16'h000E : 16'h0006);
            @(posedge ref_clk);
            flag_ack <= 4'hF;
            @(posedge ref_clk);
            flag_ack <= 4'h0;
            rdc(REG_FLAGS, 16'h0000);
        end
        // capture is not buffered: a top below the count is missed
        wr(REG_COUNT, 16'h0010);
        wr(REG_CAPTURE, 16'h0005);
        wr(REG_CTRL, 16'h010C);
        repeat (10) @(posedge ref_clk);
        wr(REG_CTRL, 16'h0000);
        rd(REG_COUNT, d);
        chk(16'(d > 16'h0014), 16'h0001);
        wr(REG_CMP_B, 16'h0001);
        wr(REG_CAPTURE, 16'h0007);
        wr(REG_COUNT, 16'h0000);
        wr(REG_CTRL, 16'h10CE);
        wr(REG_FORCE, 16'h0003);
        rdc(REG_STATUS, 16'h0000);
        for (int j = 0; j < 2; j++) begin
            wr(REG_CTRL, j ? 16'h11CE : 16'h118E);
            repeat (20) @(posedge ref_clk);
            watch(1'b1, 16, hi, tg);
            chk(16'(hi), j ? 16'h0004 : 16'h000C);
        end
        wr(REG_CTRL, 16'h1000);
        rdc(REG_FLAGS, 16'h000F);
        wr(REG_FLAGS, 16'h000F);
        wr(REG_COUNT, 16'h0000);
        wr(REG_CTRL, 16'h0105);
        repeat (300) @(posedge ref_clk);
        wr(REG_CTRL, 16'h0000);
        rd(REG_COUNT, d);
        chk(16'(d < 16'h0100), 16'h0001);
        rdc(REG_FLAGS, 16'h0007);
        results;
    end
    // whole sequence needs under a thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        fail_count++;
        results;
    end
endmodule
